// [core/bcam_pkg.sv]
// Purpose: shared constants for the channel A break match block
// Assumes: registers are 32-bit aligned words on APB, data in bits 15:0
// Notes:   offsets are byte addresses, index times four
package bcam_pkg;

  localparam int unsigned BCAM_APB_AW   = 8;
  localparam int unsigned BCAM_DATA_W   = 32;
  localparam int unsigned BCAM_HALF_W   = 16;
  localparam int unsigned BCAM_QUAL_W   = 8;

  // register byte offsets
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_CMP_HI  = 8'h00;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_CMP_LO  = 8'h04;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_MSK_HI  = 8'h08;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_MSK_LO  = 8'h0c;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_QUAL    = 8'h10;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_IRQ_STS = 8'h14;
  localparam logic [BCAM_APB_AW-1:0] BCAM_OFS_IRQ_MSK = 8'h18;

  // power-on reset values
  localparam logic [BCAM_HALF_W-1:0] BCAM_RST_HALF = 16'h0000;
  localparam logic [BCAM_QUAL_W-1:0] BCAM_RST_QUAL = 8'h00;

  // qualifier field positions
  localparam int unsigned BCAM_MST_LSB = 6;
  localparam int unsigned BCAM_ACC_LSB = 4;
  localparam int unsigned BCAM_DIR_LSB = 2;
  localparam int unsigned BCAM_SIZ_LSB = 0;

  // two-bit select encodings shared by master, access type and direction
  localparam logic [1:0] BCAM_SEL_OFF  = 2'h0;
  localparam logic [1:0] BCAM_SEL_ONE  = 2'h1;
  localparam logic [1:0] BCAM_SEL_TWO  = 2'h2;
  localparam logic [1:0] BCAM_SEL_BOTH = 2'h3;

  // operand size codes
  localparam logic [1:0] BCAM_SIZE_ANY  = 2'h0;
  localparam logic [1:0] BCAM_SIZE_BYTE = 2'h1;
  localparam logic [1:0] BCAM_SIZE_WORD = 2'h2;
  localparam logic [1:0] BCAM_SIZE_LONG = 2'h3;

  // byte lanes that carry the 16-bit register data
  localparam logic [3:0] BCAM_STRB_HALF = 4'h3;

endpackage

// [core/bcam_match.sv]
// Purpose: combinational condition compare for one bus cycle
// Assumes: cycle attributes valid in the same cycle as cyc_valid
// Notes:   purely combinational, registered by the parent
`timescale 1ns/100ps
`default_nettype none
module bcam_match #(
  parameter int unsigned ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0]             cmp_addr,
  input  wire logic [ADDR_W-1:0]             addr_mask,
  input  wire logic [bcam_pkg::BCAM_QUAL_W-1:0] qual,
  input  wire logic                          cyc_valid,
  input  wire logic [ADDR_W-1:0]             cyc_addr,
  input  wire logic                          cyc_dma,
  input  wire logic                          cyc_ifetch,
  input  wire logic                          cyc_write,
  input  wire logic [1:0]                    cyc_size,
  output logic                               match
);
  import bcam_pkg::*;

  logic [ADDR_W-1:0] bit_ok;
  logic [1:0]        mst_sel;
  logic [1:0]        acc_sel;
  logic [1:0]        dir_sel;
  logic [1:0]        siz_sel;
  logic [1:0]        eff_size;
  logic              mst_ok;
  logic              acc_ok;
  logic              dir_ok;
  logic              siz_ok;

  genvar n;
  generate
    for (n = 0; n < ADDR_W; n++)
    begin : g_bit
      // a set mask bit drops the bit from the compare
      assign bit_ok[n] = addr_mask[n] | (cmp_addr[n] == cyc_addr[n]); // RQ1
    end
  endgenerate

  assign mst_sel = qual[BCAM_MST_LSB +: 2];
  assign acc_sel = qual[BCAM_ACC_LSB +: 2];
  assign dir_sel = qual[BCAM_DIR_LSB +: 2];
  assign siz_sel = qual[BCAM_SIZ_LSB +: 2];

  // select bit one picks the first kind, bit two the second; zero never matches
  assign mst_ok = cyc_dma ? mst_sel[1] : mst_sel[0]; // RQ6
  assign acc_ok = cyc_ifetch ? acc_sel[0] : acc_sel[1]; // RQ7
  assign dir_ok = cyc_write ? dir_sel[1] : dir_sel[0]; // RQ8

  // fetches move a longword on the bus but count as word size
  assign eff_size = cyc_ifetch ? BCAM_SIZE_WORD : cyc_size; // RQ11 RQ12
  assign siz_ok   = (siz_sel == BCAM_SIZE_ANY) || (siz_sel == eff_size); // RQ9

  assign match = cyc_valid & (&bit_ok) & mst_ok & acc_ok & dir_ok & siz_ok; // RQ15
endmodule
`default_nettype wire

// [core/bcam_top.sv]
// Purpose: channel A break condition registers and match request
// Assumes: bus cycle inputs come from logic on pclk; presetn is power-on reset
// Notes:   APB slave with zero wait states; brk_req follows a match by one edge
//
// Summary of operation
// RQ1: mask bit 0 includes that compare-address bit, mask bit 1 excludes it.
// RQ2: mask splits into upper half for bits 31:16 and lower for 15:0.
// RQ3: both mask halves clear on power-on reset; manual reset leaves them alone.
// RQ4: cycle qualifier clears on power-on reset; manual reset leaves it alone.
// RQ5: qualifier bits 15:8 read zero; software writes zero there.
// RQ6: master select 00 off, 01 cpu, 10 dma engines, 11 either.
// RQ7: access type 00 off, 01 fetch, 10 data, 11 either.
// RQ8: direction 00 off, 01 read, 10 write, 11 either.
// RQ9: size 00 ignored, 01 byte, 10 word, 11 longword.
// RQ10: software clears low size bit when breaking on fetches.
// RQ11: every instruction fetch compares as word size.
// RQ12: data accesses compare their operand size, not the bus width.
// RQ13: compare address is 32 bits held as upper and lower halves.
// RQ14: software uses only word or longword accesses to these registers.
// RQ15: break only when address and all enabled qualifiers match one cycle.
// RQ16: a match raises a break request toward the interrupt logic.
`timescale 1ns/100ps
`default_nettype none
module bcam_top #(
  parameter int unsigned ADDR_W = 32
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               manual_reset_req,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [bcam_pkg::BCAM_APB_AW-1:0]   paddr,
  input  wire logic [bcam_pkg::BCAM_DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [bcam_pkg::BCAM_DATA_W-1:0]   prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               cyc_valid,
  input  wire logic [ADDR_W-1:0]                  cyc_addr,
  input  wire logic                               cyc_dma,
  input  wire logic                               cyc_ifetch,
  input  wire logic                               cyc_write,
  input  wire logic [1:0]                         cyc_size,
  output logic                                    brk_req,
  output logic                                    irq
);
  import bcam_pkg::*;

  localparam int unsigned HALF_W = BCAM_HALF_W;

  // the register layout is two 16-bit halves of one 32-bit address
  if (ADDR_W != 2 * HALF_W)
  begin : g_bad_width
    $error("bcam_top: ADDR_W must be twice the register half width");
  end

  typedef struct packed {
    logic [HALF_W-1:0]      cmp_hi;
    logic [HALF_W-1:0]      cmp_lo;
    logic [HALF_W-1:0]      msk_hi;
    logic [HALF_W-1:0]      msk_lo;
    logic [BCAM_QUAL_W-1:0] qual;
    logic                   sts;
    logic                   irq_en;
    logic [BCAM_DATA_W-1:0] rdata;
    logic                   brk;
  } bcam_state_s;

  bcam_state_s st_q;
  bcam_state_s st_d;

  logic              setup;
  logic              access;
  logic              hit_cmp_hi;
  logic              hit_cmp_lo;
  logic              hit_msk_hi;
  logic              hit_msk_lo;
  logic              hit_qual;
  logic              hit_sts;
  logic              hit_msk;
  logic              mapped;
  logic              lanes_ok;
  logic              wr_ok;
  logic              rd_sts;
  logic              match_now;
  logic [HALF_W-1:0] wr_half;
  logic [ADDR_W-1:0] cmp_addr;
  logic [ADDR_W-1:0] addr_mask;

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  assign hit_cmp_hi = (paddr == BCAM_OFS_CMP_HI);
  assign hit_cmp_lo = (paddr == BCAM_OFS_CMP_LO);
  assign hit_msk_hi = (paddr == BCAM_OFS_MSK_HI);
  assign hit_msk_lo = (paddr == BCAM_OFS_MSK_LO);
  assign hit_qual   = (paddr == BCAM_OFS_QUAL);
  assign hit_sts    = (paddr == BCAM_OFS_IRQ_STS);
  assign hit_msk    = (paddr == BCAM_OFS_IRQ_MSK);
  assign mapped     = hit_cmp_hi | hit_cmp_lo | hit_msk_hi | hit_msk_lo
                    | hit_qual | hit_sts | hit_msk;

  // a write that leaves out a lane of the 16-bit data is refused, not merged
  assign lanes_ok = ((pstrb & BCAM_STRB_HALF) == BCAM_STRB_HALF); // RQ14
  assign wr_ok    = access & pwrite & mapped & lanes_ok;
  assign rd_sts   = access & ~pwrite & hit_sts;
  assign wr_half  = pwdata[HALF_W-1:0];

  // zero wait states keeps the decode cheap; errors flag unmapped accesses or narrow writes
  assign pready  = 1'b1;
  assign pslverr = access & (~mapped | (pwrite & ~lanes_ok));

  assign cmp_addr  = {st_q.cmp_hi, st_q.cmp_lo}; // RQ13
  assign addr_mask = {st_q.msk_hi, st_q.msk_lo}; // RQ2

  bcam_match #(
    .ADDR_W (ADDR_W)
  ) u_match (
    .cmp_addr   (cmp_addr),
    .addr_mask  (addr_mask),
    .qual       (st_q.qual),
    .cyc_valid  (cyc_valid),
    .cyc_addr   (cyc_addr),
    .cyc_dma    (cyc_dma),
    .cyc_ifetch (cyc_ifetch),
    .cyc_write  (cyc_write),
    .cyc_size   (cyc_size),
    .match      (match_now)
  );

  always_comb
  begin
    st_d = st_q;

    if (wr_ok && hit_cmp_hi)
    begin
      st_d.cmp_hi = wr_half;
    end
    if (wr_ok && hit_cmp_lo)
    begin
      st_d.cmp_lo = wr_half;
    end
    if (wr_ok && hit_msk_hi)
    begin
      st_d.msk_hi = wr_half; // RQ2
    end
    if (wr_ok && hit_msk_lo)
    begin
      st_d.msk_lo = wr_half; // RQ2
    end
    if (wr_ok && hit_qual)
    begin
      // upper bits are not stored, so they can never read back as one
      st_d.qual = pwdata[BCAM_QUAL_W-1:0]; // RQ5
    end
    if (wr_ok && hit_msk)
    begin
      st_d.irq_en = pwdata[0];
    end

    // read data is fetched in the setup phase so prdata comes from a flop
    if (setup && !pwrite)
    begin
      st_d.rdata = '0;
      unique case (1'b1)
        hit_cmp_hi: st_d.rdata[HALF_W-1:0]      = st_q.cmp_hi;
        hit_cmp_lo: st_d.rdata[HALF_W-1:0]      = st_q.cmp_lo;
        hit_msk_hi: st_d.rdata[HALF_W-1:0]      = st_q.msk_hi;
        hit_msk_lo: st_d.rdata[HALF_W-1:0]      = st_q.msk_lo;
        hit_qual:   st_d.rdata[BCAM_QUAL_W-1:0] = st_q.qual; // RQ5
        hit_sts:    st_d.rdata[0]               = st_q.sts;
        hit_msk:    st_d.rdata[0]               = st_q.irq_en;
        default:    st_d.rdata                  = '0;
      endcase
    end

    // a match in the clearing cycle is kept: set beats clear
    st_d.sts = match_now | (st_q.sts & ~rd_sts & ~manual_reset_req);

    st_d.brk = match_now; // RQ16
  end

  // manual reset leaves the condition registers as they are
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.cmp_hi <= BCAM_RST_HALF;
      st_q.cmp_lo <= BCAM_RST_HALF;
      st_q.msk_hi <= BCAM_RST_HALF; // RQ3
      st_q.msk_lo <= BCAM_RST_HALF; // RQ3
      st_q.qual   <= BCAM_RST_QUAL; // RQ4
      st_q.sts    <= 1'b0;
      st_q.irq_en <= 1'b0;
      st_q.rdata  <= '0;
      st_q.brk    <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign brk_req = st_q.brk;
  assign irq     = st_q.sts & st_q.irq_en;
endmodule
`default_nettype wire

// [tb/bcam_top_sva.sv]
// Purpose: port checks of the channel A break match
// Assumes: register writes land on the apb access edge
// Notes: shadows the condition registers, so a refused write is never shadowed
`timescale 1ns/100ps
`default_nettype none
module bcam_top_sva
  import bcam_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic        cyc_dma,
  input wire logic        cyc_ifetch,
  input wire logic [1:0]  cyc_size,
  input wire logic        brk_req
);
  logic [15:0] sh_q [4];
  logic [7:0]  ql_q;
  wire logic   wr_w = psel && penable && pwrite && pstrb[1:0] == 2'h3;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sh_q <= '{default: 16'h0000};
      ql_q <= 8'h00;
    end
    else if (wr_w && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0)
      sh_q[paddr[3:2]] <= pwdata[15:0];
    else if (wr_w && paddr == BCAM_OFS_QUAL)
      ql_q <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_brk_cause: assert property (brk_req |-> $past(cyc_valid)) else $error("break without cycle");
  a_addr_mask: assert property (cyc_valid && (((cyc_addr ^ {sh_q[0], sh_q[1]}) & ~{sh_q[2], sh_q[3]}) != 32'h0)
    |=> !brk_req) else $error("break on address miss");
  a_master_off: assert property (cyc_valid && ql_q[7:6] == 2'h0 |=> !brk_req) else $error("master off");
  a_cpu_only: assert property (cyc_valid && cyc_dma && ql_q[7:6] == 2'h1 |=> !brk_req) else $error("dma hit");
  a_access_off: assert property (cyc_valid && ql_q[5:4] == 2'h0 |=> !brk_req) else $error("access off");
  a_dir_off: assert property (cyc_valid && ql_q[3:2] == 2'h0 |=> !brk_req) else $error("direction off");
  a_fetch_word: assert property (cyc_valid && cyc_ifetch && ql_q[0] |=> !brk_req) else $error("fetch size");
  a_data_size: assert property (cyc_valid && !cyc_ifetch && ql_q[1:0] != 2'h0 && cyc_size != ql_q[1:0]
    |=> !brk_req) else $error("data size");
  a_qual_rsvd: assert property (psel && !penable && !pwrite && paddr == BCAM_OFS_QUAL
    |=> prdata[31:8] == 24'h0) else $error("reserved bits set");
endmodule
bind bcam_top bcam_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .cyc_valid, .cyc_addr, .cyc_dma, .cyc_ifetch, .cyc_size, .brk_req);
`default_nettype wire

// [tb/bcam_bus_src.sv]
// Purpose: cpu and dma bus cycle source
// Assumes: one cycle per call
// Notes: released lines show inverted values, not the last cycle
`timescale 1ns/100ps
`default_nettype none
module bcam_bus_src (
  input  wire logic        pclk,
  output logic             cyc_valid,
  output logic [31:0]      cyc_addr,
  output logic             cyc_dma,
  output logic             cyc_ifetch,
  output logic             cyc_write,
  output logic [1:0]       cyc_size
);
  initial {cyc_valid, cyc_addr, cyc_dma, cyc_ifetch, cyc_write, cyc_size} = '0;
  // k is {dma, fetch, write, size}; fetches report the long transfer they really make
  task automatic issue(input logic [31:0] a, input logic [4:0] k);
    @(posedge pclk);
    {cyc_valid, cyc_addr, cyc_dma, cyc_ifetch, cyc_write, cyc_size} <= {1'b1, a, k};
    @(posedge pclk);
    {cyc_valid, cyc_addr, cyc_dma, cyc_ifetch, cyc_write, cyc_size} <= {1'b0, ~a, ~k};
  endtask
endmodule
`default_nettype wire

// [tb/bcam_top_tb_top.sv]
// Purpose: register and match tests of the channel A break block
// Assumes: zero wait apb slave, break one edge after the cycle
// Notes: compare address 12345678, low mask 00ff throughout the match table
`timescale 1ns/100ps
`default_nettype none
module bcam_top_tb_top;
  import bcam_pkg::*;
  typedef struct packed {logic [7:0] q; logic [31:0] a; logic [4:0] k; logic e;} bcam_row_s;
  localparam logic [31:0] HIT = 32'h12345678;
  logic pclk, presetn, manual_reset_req, psel, penable, pwrite, brk_req, irq, pready, pslverr;
  logic cyc_valid, cyc_dma, cyc_ifetch, cyc_write;
  logic [1:0] cyc_size;
  logic [3:0] pstrb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cyc_addr;
  int err_total, n_checks;
  logic last_err;
  bcam_row_s tbl [17] = '{
    '{8'h00, HIT, 5'h02, 1'b0},
    '{8'h7e, HIT, 5'h02, 1'b1},
    '{8'h7e, HIT, 5'h12, 1'b0},
    '{8'hbe, HIT, 5'h12, 1'b1},
    '{8'hfe, HIT, 5'h12, 1'b1},
    '{8'hde, HIT, 5'h02, 1'b0},
    '{8'hde, HIT, 5'h0b, 1'b1},
    '{8'hee, HIT, 5'h0b, 1'b0},
    '{8'hcc, HIT, 5'h02, 1'b0},
    '{8'hf6, HIT, 5'h06, 1'b0},
    '{8'hfa, HIT, 5'h06, 1'b1},
    '{8'hf0, HIT, 5'h02, 1'b0},
    '{8'hfd, HIT, 5'h0b, 1'b0},
    '{8'hfd, HIT, 5'h01, 1'b1},
    '{8'hff, HIT, 5'h02, 1'b0},
    '{8'hfc, 32'h123456a5, 5'h03, 1'b1},
    '{8'hfc, 32'h12355678, 5'h03, 1'b0}};
  bcam_top dut (.pclk(pclk), .presetn(presetn), .manual_reset_req(manual_reset_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_dma(cyc_dma),
    .cyc_ifetch(cyc_ifetch), .cyc_write(cyc_write), .cyc_size(cyc_size), .brk_req(brk_req), .irq(irq));
  bcam_bus_src u_src (.pclk(pclk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_dma(cyc_dma),
    .cyc_ifetch(cyc_ifetch), .cyc_write(cyc_write), .cyc_size(cyc_size));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  // waits for pready at most 50 edges, a hang is a mismatch
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
    begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk("prdata", e, r);
  endtask
  initial
  begin
    {presetn, manual_reset_req, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(BCAM_OFS_MSK_HI, 32'h0);
    rd(BCAM_OFS_MSK_LO, 32'h0);
    rd(BCAM_OFS_QUAL, 32'h0);
    wr(BCAM_OFS_QUAL, 32'hffff);
    rd(BCAM_OFS_QUAL, 32'h00ff);
    wr(BCAM_OFS_CMP_HI, 32'h1234);
    wr(BCAM_OFS_CMP_LO, 32'h5678);
    wr(BCAM_OFS_MSK_LO, 32'h00ff);
    chk("pslverr", 32'h0, {31'h0, last_err});
    rd(BCAM_OFS_MSK_LO, 32'h00ff);
    // a byte-lane write is outside what software may do, so it must be refused
    pstrb <= 4'h1;
    wr(BCAM_OFS_MSK_HI, 32'hffff);
    chk("pslverr", 32'h1, {31'h0, last_err});
    pstrb <= 4'hf;
    rd(BCAM_OFS_MSK_HI, 32'h0);
    rd(8'h1c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, last_err});
    $display("test registers done");
    wr(BCAM_OFS_IRQ_MSK, 32'h1);
    foreach (tbl[i])
    begin
      wr(BCAM_OFS_QUAL, {24'h0, tbl[i].q});
      u_src.issue(tbl[i].a, tbl[i].k);
      #1 chk("brk_req", {31'h0, tbl[i].e}, {31'h0, brk_req});
      chk("irq", {31'h0, tbl[i].e}, {31'h0, irq});
      rd(BCAM_OFS_IRQ_STS, {31'h0, tbl[i].e});
    end
    $display("test match done");
    wr(BCAM_OFS_IRQ_MSK, 32'h0);
    u_src.issue(HIT, 5'h03);
    #1 chk("irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    manual_reset_req <= 1'b1;
    @(posedge pclk);
    manual_reset_req <= 1'b0;
    rd(BCAM_OFS_IRQ_STS, 32'h0);
    rd(BCAM_OFS_MSK_LO, 32'h00ff);
    rd(BCAM_OFS_QUAL, 32'h00fc);
    u_src.issue(HIT, 5'h03);
    rd(BCAM_OFS_IRQ_STS, 32'h1);
    $display("test interrupt done");
    // a second power-on reset must wipe values written earlier
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(BCAM_OFS_MSK_LO, 32'h0);
    rd(BCAM_OFS_QUAL, 32'h0);
    rd(BCAM_OFS_CMP_LO, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
